// [logic/tone_port_pkg.sv]
package tone_port_pkg;

	// =====================================================================
	// Timing
	// =====================================================================
	localparam int CLK_MHZ = 250;
	localparam int POWERUP_MS = 100;
	localparam int TX_READY_MS = 100;
	localparam int EXT_FACTOR = 2;
	localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
	// Burst and pause are equal halves of the ready delay.
	localparam int BURST_CYC = TX_READY_MS * 1000 * CLK_MHZ / 2;
	localparam int STROBE_CYC = 4;
	localparam int HOLD_CYC = 2;

	// =====================================================================
	// Device register fields
	// =====================================================================
	localparam int ST_IRQ = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_RX_FULL = 2;
	localparam int ST_STEER = 3;
	localparam int CA_TONE = 0;
	localparam int CA_CP = 1;
	localparam int CA_IRQ_EN = 2;
	localparam int CA_SEL_B = 3;
	localparam int CB_BURST_OFF = 0;
	localparam int CB_TEST = 1;
	localparam int CB_SINGLE = 2;
	localparam int CB_COLUMN = 3;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_SEL_B = 4'h8;
	localparam logic [3:0] BUS_IDLE = 4'hF;

	// =====================================================================
	// Controller registers on APB
	// =====================================================================
	localparam logic [7:0] A_TX = 8'h00;
	localparam logic [7:0] A_RX = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_MASK = 8'h0C;
	localparam logic [7:0] A_CFG = 8'h10;
	localparam int EV_INIT = 0;
	localparam int EV_RX = 1;
	localparam int EV_TX = 2;
	localparam int CFG_POLL = 8;
	localparam logic [8:0] CFG_RESET = 9'h105;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [2:0] INIT_LAST = 3'h7;

endpackage

// [logic/tone_bus_if.sv]
`timescale 1ns/100ps
interface tone_bus_if;
	logic register_select;
	logic wr_n;
	logic rd_n;
	logic [3:0] host_dout;
	logic host_oe_n;
	logic [3:0] dev_dout;
	logic dev_oe_n;
	logic irq_oe_n;
	logic [3:0] data;
	logic interrupt_or_progress_pin_n;

	// Pulled-up shared nibble and open-drain interrupt line.
	assign data = !host_oe_n ? host_dout : (!dev_oe_n ? dev_dout : tone_port_pkg::BUS_IDLE);
	assign interrupt_or_progress_pin_n = irq_oe_n;

	modport device (
		input register_select,
		input wr_n,
		input rd_n,
		input data,
		output dev_dout,
		output dev_oe_n,
		output irq_oe_n
	);
	modport host (
		output register_select,
		output wr_n,
		output rd_n,
		output host_dout,
		output host_oe_n,
		input data,
		input interrupt_or_progress_pin_n
	);
endinterface

// [logic/tone_transceiver_port.sv]
// Notes on behaviour
// - Host begins init sequence 100 ms after power-up.
// - Select high: write control, read status.
// - Control A: tone, tone mode, interrupt, select B.
// - Control B all zeros selects burst mode.
// - Select low write loads transmit digit code.
// - Select low read returns received digit.
// - Host waits interrupt or polls before servicing.
// - Status bit 1 means transmitter ready.
// - Status bit 2 means digit received.
// - Both set: read receive, then write transmit.
// - Burst: ready set 100 ms after write.
// - Extended burst doubles delay to 200 ms.
// - Status read clears flags; no-burst clears ready.
// - Status bit 0 is bit 1 or 2.
`timescale 1ns/100ps
module tone_transceiver_port #(
	parameter int BURST_CYC = tone_port_pkg::BURST_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	tone_bus_if.device bus,
	input wire logic rx_valid,
	input wire logic [3:0] rx_code,
	input wire logic steer_absent,
	output logic tone_active,
	output logic [3:0] tone_code,
	output logic call_progress_select,
	output logic single_tone,
	output logic column_tone,
	output logic test_mode
);

	// =====================================================================
	// State
	// =====================================================================
	typedef struct packed {
		logic wr_n_d;
		logic rd_n_d;
		logic [3:0] ctl_a;
		logic [3:0] ctl_b;
		logic [3:0] tx_data;
		logic [3:0] rx_data;
		logic [3:0] dout;
		logic dout_oe_n;
		logic irq_oe_n;
		logic tx_empty;
		logic rx_full;
		logic steer;
		logic busy;
		logic in_burst;
		logic tone_pin;
		logic [25:0] cnt;
	} dev_s;

	dev_s r_reg;
	dev_s r_next;
	logic wr_end;
	logic rd_end;
	logic burst_mode;
	logic [25:0] phase_len;
	logic [3:0] status_nib;

	// =====================================================================
	// Next state
	// =====================================================================
	always_comb
	begin
		r_next = r_reg;
		r_next.wr_n_d = bus.wr_n;
		r_next.rd_n_d = bus.rd_n;
		r_next.steer = steer_absent;
		// Strobes act on their rising edge so select and data are settled.
		wr_end = !r_reg.wr_n_d && bus.wr_n;
		rd_end = !r_reg.rd_n_d && bus.rd_n;
		burst_mode = !r_reg.ctl_b[tone_port_pkg::CB_BURST_OFF];
		if (r_reg.ctl_a[tone_port_pkg::CA_CP])
		begin
			phase_len = 26'(BURST_CYC * tone_port_pkg::EXT_FACTOR);
		end
		else
		begin
			phase_len = 26'(BURST_CYC);
		end
		status_nib = {r_reg.steer, r_reg.rx_full, r_reg.tx_empty,
			r_reg.rx_full | r_reg.tx_empty};

		// Read data is driven one cycle behind the read strobe, for as many cycles as it is low.
		r_next.dout_oe_n = bus.rd_n;
		if (bus.register_select)
		begin
			r_next.dout = status_nib;
		end
		else
		begin
			r_next.dout = r_reg.rx_data;
		end

		if (wr_end)
		begin
			if (bus.register_select)
			begin
				if (r_reg.ctl_a[tone_port_pkg::CA_SEL_B])
				begin
					// One write to B, then the pointer falls back to A.
					r_next.ctl_b = bus.data;
					r_next.ctl_a[tone_port_pkg::CA_SEL_B] = 1'b0;
				end
				else
				begin
					r_next.ctl_a = bus.data;
				end
			end
			else
			begin
				r_next.tx_data = bus.data;
				if (burst_mode)
				begin
					r_next.busy = 1'b1;
					r_next.in_burst = 1'b1;
					r_next.cnt = phase_len;
				end
			end
		end

		// Clears first, so that an event in the same cycle still lands.
		if (rd_end && bus.register_select)
		begin
			r_next.tx_empty = 1'b0;
			r_next.rx_full = 1'b0;
		end

		if (r_reg.busy && !(wr_end && !bus.register_select))
		begin
			if (r_reg.cnt <= 26'h0000001)
			begin
				if (r_reg.in_burst)
				begin
					r_next.in_burst = 1'b0;
					r_next.cnt = phase_len;
				end
				else
				begin
					r_next.busy = 1'b0;
					r_next.tx_empty = 1'b1;
				end
			end
			else
			begin
				r_next.cnt = r_reg.cnt - 26'h0000001;
			end
		end

		if (rx_valid)
		begin
			r_next.rx_data = rx_code;
			r_next.rx_full = 1'b1;
		end

		if (r_next.ctl_b[tone_port_pkg::CB_BURST_OFF])
		begin
			// Leaving burst mode abandons any timed burst in progress.
			r_next.tx_empty = 1'b0;
			r_next.busy = 1'b0;
			r_next.in_burst = 1'b0;
			r_next.tone_pin = r_next.ctl_a[tone_port_pkg::CA_TONE];
		end
		else
		begin
			r_next.tone_pin = r_next.ctl_a[tone_port_pkg::CA_TONE] && r_next.in_burst;
		end

		r_next.irq_oe_n = !(r_next.ctl_a[tone_port_pkg::CA_IRQ_EN]
			&& (r_next.tx_empty || r_next.rx_full));
	end

	// =====================================================================
	// Registers
	// =====================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= '0;
			r_reg.wr_n_d <= 1'b1;
			r_reg.rd_n_d <= 1'b1;
			r_reg.dout_oe_n <= 1'b1;
			r_reg.irq_oe_n <= 1'b1;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	assign bus.dev_dout = r_reg.dout;
	assign bus.dev_oe_n = r_reg.dout_oe_n;
	assign bus.irq_oe_n = r_reg.irq_oe_n;
	assign tone_active = r_reg.tone_pin;
	assign tone_code = r_reg.tx_data;
	assign call_progress_select = r_reg.ctl_a[tone_port_pkg::CA_CP];
	assign single_tone = r_reg.ctl_b[tone_port_pkg::CB_SINGLE];
	assign column_tone = r_reg.ctl_b[tone_port_pkg::CB_COLUMN];
	assign test_mode = r_reg.ctl_b[tone_port_pkg::CB_TEST];

endmodule

// [logic/tone_host_sequencer.sv]
`timescale 1ns/100ps
module tone_host_sequencer #(
	parameter int POWERUP_CYC = tone_port_pkg::POWERUP_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	tone_bus_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);

	// =====================================================================
	// State
	// =====================================================================
	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_SETUP = 2'b01,
		P_STROBE = 2'b10,
		P_HOLD = 2'b11
	} phase_e;

	typedef enum logic [2:0] {
		S_POWER = 3'b000,
		S_INIT = 3'b001,
		S_IDLE = 3'b010,
		S_STAT = 3'b011,
		S_RX = 3'b100,
		S_TX = 3'b101
	} seq_e;

	typedef struct packed {
		phase_e phase;
		seq_e seq;
		logic [2:0] idx;
		logic [2:0] pcnt;
		logic [24:0] wait_cnt;
		logic rs;
		logic wr_n;
		logic rd_n;
		logic op_rd;
		logic [3:0] dout;
		logic oe_n;
		logic [3:0] got;
		logic [3:0] stat;
		logic [3:0] tx_digit;
		logic tx_pending;
		logic tx_idle;
		logic [3:0] rx_digit;
		logic [2:0] ev;
		logic [2:0] mask;
		logic [8:0] cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} host_s;

	host_s r_reg;
	host_s r_next;
	logic done;
	logic launch;
	logic [5:0] op;
	logic [2:0] ev_set;
	logic apb_wr;

	// Op is {read, select, nibble}.
	function automatic logic [5:0] init_op(input logic [2:0] idx, input logic [8:0] cfg);
		unique case (idx)
			3'h0: init_op = {2'b11, tone_port_pkg::NIB_ZERO};
			3'h1: init_op = {2'b01, tone_port_pkg::NIB_ZERO};
			3'h2: init_op = {2'b01, tone_port_pkg::NIB_ZERO};
			3'h3: init_op = {2'b01, tone_port_pkg::NIB_SEL_B};
			3'h4: init_op = {2'b01, tone_port_pkg::NIB_ZERO};
			3'h5: init_op = {2'b11, tone_port_pkg::NIB_ZERO};
			3'h6: init_op = {2'b01, 1'b1, cfg[2:0]};
			3'h7: init_op = {2'b01, cfg[7:4]};
		endcase
	endfunction

	// =====================================================================
	// Next state
	// =====================================================================
	always_comb
	begin
		r_next = r_reg;
		ev_set = 3'h0;
		done = 1'b0;
		launch = 1'b0;
		op = {2'b11, tone_port_pkg::NIB_ZERO};

		// Strobe engine: setup, strobe low, hold with select still valid.
		unique case (r_reg.phase)
			P_IDLE:
			begin
				r_next.oe_n = 1'b1;
			end
			P_SETUP:
			begin
				r_next.phase = P_STROBE;
				r_next.pcnt = 3'(tone_port_pkg::STROBE_CYC - 1);
				r_next.rd_n = !r_reg.op_rd;
				r_next.wr_n = r_reg.op_rd;
			end
			P_STROBE:
			begin
				if (r_reg.pcnt == 3'h0)
				begin
					r_next.got = bus.data;
					r_next.rd_n = 1'b1;
					r_next.wr_n = 1'b1;
					r_next.phase = P_HOLD;
					r_next.pcnt = 3'(tone_port_pkg::HOLD_CYC - 1);
				end
				else
				begin
					r_next.pcnt = r_reg.pcnt - 3'h1;
				end
			end
			P_HOLD:
			begin
				if (r_reg.pcnt == 3'h0)
				begin
					r_next.phase = P_IDLE;
					r_next.oe_n = 1'b1;
					done = 1'b1;
				end
				else
				begin
					r_next.pcnt = r_reg.pcnt - 3'h1;
				end
			end
		endcase

		unique case (r_reg.seq)
			S_POWER:
			begin
				if (r_reg.wait_cnt >= 25'(POWERUP_CYC - 1))
				begin
					r_next.seq = S_INIT;
				end
				else
				begin
					r_next.wait_cnt = r_reg.wait_cnt + 25'h0000001;
				end
			end
			S_INIT:
			begin
				op = init_op(r_reg.idx, r_reg.cfg);
				launch = 1'b1;
				if (done)
				begin
					r_next.idx = r_reg.idx + 3'h1;
					if (r_reg.idx == tone_port_pkg::INIT_LAST)
					begin
						r_next.seq = S_IDLE;
						ev_set[tone_port_pkg::EV_INIT] = 1'b1;
					end
				end
			end
			S_IDLE:
			begin
				if (r_reg.tx_pending && r_reg.tx_idle)
				begin
					r_next.seq = S_TX;
				end
				else if (!bus.interrupt_or_progress_pin_n || r_reg.cfg[tone_port_pkg::CFG_POLL])
				begin
					r_next.seq = S_STAT;
				end
			end
			S_STAT:
			begin
				op = {2'b11, tone_port_pkg::NIB_ZERO};
				launch = 1'b1;
				if (done)
				begin
					r_next.stat = r_reg.got;
					if (r_reg.got[tone_port_pkg::ST_RX_FULL])
					begin
						r_next.seq = S_RX;
					end
					else
					begin
						r_next.seq = S_IDLE;
						r_next.tx_idle = r_reg.tx_idle | r_reg.got[tone_port_pkg::ST_TX_EMPTY];
					end
				end
			end
			S_RX:
			begin
				op = {2'b10, tone_port_pkg::NIB_ZERO};
				launch = 1'b1;
				if (done)
				begin
					r_next.rx_digit = r_reg.got;
					ev_set[tone_port_pkg::EV_RX] = 1'b1;
					r_next.tx_idle = r_reg.tx_idle | r_reg.stat[tone_port_pkg::ST_TX_EMPTY];
					r_next.seq = S_IDLE;
				end
			end
			S_TX:
			begin
				op = {2'b00, r_reg.tx_digit};
				launch = 1'b1;
				if (done)
				begin
					r_next.tx_pending = 1'b0;
					r_next.tx_idle = 1'b0;
					ev_set[tone_port_pkg::EV_TX] = 1'b1;
					r_next.seq = S_IDLE;
				end
			end
			default:
			begin
				r_next.seq = S_IDLE;
			end
		endcase

		if (launch && r_reg.phase == P_IDLE)
		begin
			r_next.phase = P_SETUP;
			r_next.op_rd = op[5];
			r_next.rs = op[4];
			r_next.dout = op[3:0];
			r_next.oe_n = op[5];
		end

		// APB slave: zero wait states, answer prepared in the setup cycle.
		apb_wr = psel && penable && r_reg.pready && pwrite;
		r_next.pready = psel && !penable && !r_reg.pready;
		if (psel && !penable)
		begin
			r_next.pslverr = 1'b0;
			unique case (paddr)
				tone_port_pkg::A_TX: r_next.prdata = {27'h0, r_reg.tx_pending, r_reg.tx_digit};
				tone_port_pkg::A_RX: r_next.prdata = {28'h0, r_reg.rx_digit};
				tone_port_pkg::A_STATUS: r_next.prdata = {20'h0, r_reg.stat, 5'h0, r_reg.ev};
				tone_port_pkg::A_MASK: r_next.prdata = {29'h0, r_reg.mask};
				tone_port_pkg::A_CFG: r_next.prdata = {23'h0, r_reg.cfg};
				default:
				begin
					r_next.prdata = 32'h0;
					r_next.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr && paddr == tone_port_pkg::A_TX)
		begin
			r_next.tx_digit = pwdata[3:0];
			r_next.tx_pending = 1'b1;
		end
		if (apb_wr && paddr == tone_port_pkg::A_MASK)
		begin
			r_next.mask = pwdata[2:0];
		end
		if (apb_wr && paddr == tone_port_pkg::A_CFG)
		begin
			r_next.cfg = pwdata[8:0];
		end
		if (apb_wr && paddr == tone_port_pkg::A_STATUS)
		begin
			r_next.ev = r_reg.ev & ~pwdata[2:0];
		end
		r_next.ev = r_next.ev | ev_set;
		r_next.irq = |(r_next.ev & r_next.mask);
	end

	// =====================================================================
	// Registers
	// =====================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= '0;
			r_reg.wr_n <= 1'b1;
			r_reg.rd_n <= 1'b1;
			r_reg.oe_n <= 1'b1;
			r_reg.tx_idle <= 1'b1;
			r_reg.mask <= tone_port_pkg::MASK_RESET;
			r_reg.cfg <= tone_port_pkg::CFG_RESET;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign bus.register_select = r_reg.rs;
	assign bus.wr_n = r_reg.wr_n;
	assign bus.rd_n = r_reg.rd_n;
	assign bus.host_dout = r_reg.dout;
	assign bus.host_oe_n = r_reg.oe_n;
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign irq = r_reg.irq;

endmodule

// [tb/tone_port_chk.sv]
`timescale 1ns/100ps
// ==========
// Nibble bus checker
module tone_port_chk #(
	parameter int POWERUP_CYC = 200,
	parameter int BURST_CYC = 50
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic register_select,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [3:0] host_dout,
	input wire logic host_oe_n,
	input wire logic dev_oe_n,
	input wire logic [3:0] data,
	input wire logic interrupt_or_progress_pin_n
);
	int up_cnt;
	int tx_cnt;
	logic wr_q;
	logic st_rd;
	assign st_rd = register_select && !rd_n && !dev_oe_n;
	// The digit counter restarts at the edge where the device takes a data write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			up_cnt <= 0;
			tx_cnt <= 0;
			wr_q <= 1'b1;
		end
		else
		begin
			wr_q <= wr_n;
			up_cnt <= (up_cnt < POWERUP_CYC) ? up_cnt + 1 : up_cnt;
			tx_cnt <= (wr_n && !wr_q && !register_select) ? 0 : tx_cnt + 1;
		end
	end
	// ==========
	// Assertions
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_strobe_excl: assert property (wr_n || rd_n) else $error("both strobes low");
	a_bus_excl: assert property (host_oe_n || dev_oe_n) else $error("bus contention");
	a_write_width:
		assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n) else $error("write strobe width");
	a_read_drive:
		assert property ($fell(rd_n) |=> !dev_oe_n [*4] ##1 dev_oe_n) else $error("read drive");
	a_write_hold:
		assert property (!wr_n |-> !host_oe_n && $stable(host_dout) && $stable(register_select))
		else $error("write data moved");
	a_powerup_wait:
		assert property ($fell(wr_n) || $fell(rd_n) |-> up_cnt >= POWERUP_CYC)
		else $error("access too early");
	a_ready_early:
		assert property (st_rd && data[1] |-> tx_cnt >= 2 * BURST_CYC) else $error("ready early");
	a_flag_sum:
		assert property (st_rd |-> data[0] == (data[1] || data[2])) else $error("flag sum");
	a_pin_flag:
		assert property ($fell(rd_n) && register_select && !interrupt_or_progress_pin_n |-> ##2 data[0])
		else $error("pin without flag");
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
	localparam int B = 50;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slverr_q;
	logic irq;
	logic rx_valid;
	logic [3:0] rx_code;
	logic steer_absent;
	logic tone_active;
	logic [3:0] tone_code;
	logic cp_sel;
	logic single_tone;
	logic column_tone;
	logic test_mode;
	logic [5:0] ops[$];
	int op_t[$];
	logic [5:0] cur;
	logic cur_v;
	int cyc;
	int errors;
	int compares;
	tone_bus_if bus();
	tone_transceiver_port #(.BURST_CYC(B)) u_tone_transceiver_port (
		.pclk(pclk),
		.presetn(presetn),
		.bus(bus.device),
		.rx_valid(rx_valid),
		.rx_code(rx_code),
		.steer_absent(steer_absent),
		.tone_active(tone_active),
		.tone_code(tone_code),
		.call_progress_select(cp_sel),
		.single_tone(single_tone),
		.column_tone(column_tone),
		.test_mode(test_mode)
	);
	tone_host_sequencer #(.POWERUP_CYC(200)) u_tone_host_sequencer (
		.pclk(pclk),
		.presetn(presetn),
		.bus(bus.host),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.irq(irq)
	);
	tone_port_chk #(.POWERUP_CYC(200), .BURST_CYC(B)) u_tone_port_chk (
		.pclk(pclk),
		.presetn(presetn),
		.register_select(bus.register_select),
		.wr_n(bus.wr_n),
		.rd_n(bus.rd_n),
		.host_dout(bus.host_dout),
		.host_oe_n(bus.host_oe_n),
		.dev_oe_n(bus.dev_oe_n),
		.data(bus.data),
		.interrupt_or_progress_pin_n(bus.interrupt_or_progress_pin_n)
	);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ==========
	// Bus log: each finished access as {write, select, nibble} and its cycle
	always @(posedge pclk)
	begin
		// Counted by non-blocking assignment, so that a wait on it ends at a fixed edge.
		cyc <= cyc + 1;
		if (!bus.wr_n || !bus.rd_n)
			cur = {!bus.wr_n, bus.register_select, bus.data};
		else if (cur_v)
		begin
			ops.push_back(cur);
			op_t.push_back(cyc);
		end
		cur_v = !bus.wr_n || !bus.rd_n;
	end
	// ==========
	// Tasks
	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			summarize();
		end
		q = prdata;
		slverr_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll(input logic [7:0] a, input int b);
		logic [31:0] q;
		for (int n = 0; n < 300; n++)
		begin
			apb(1'b0, a, 32'h0, q);
			if (q[b] === 1'b1)
				return;
		end
		errors++;
		summarize();
	endtask
	// Waits for the first logged access from index s that matches v under mask m.
	task automatic wait_op(input logic [5:0] m, input logic [5:0] v, input int s, output int k);
		k = s;
		for (int n = 0; n < 2000; n++)
		begin
			while (k < ops.size() && (ops[k] & m) !== v)
				k++;
			if (k < ops.size())
				return;
			@(posedge pclk);
		end
		errors++;
		summarize();
	endtask
	task automatic till(input int c);
		while (cyc < c)
			@(posedge pclk);
	endtask
	task automatic phase(input logic [8:0] cfg, input int m);
		logic [31:0] q;
		logic [5:0] e[8];
		int k;
		int k2;
		int i;
		int t;
		int dt;
		steer_absent <= m[1];
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		ops.delete();
		op_t.delete();
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, tone_port_pkg::A_CFG, 32'h0, q);
		chk("cfg reset", 32'h105, q);
		apb(1'b0, tone_port_pkg::A_MASK, 32'h0, q);
		chk("mask reset", 32'h0, q);
		apb(1'b1, tone_port_pkg::A_CFG, {23'h0, cfg}, q);
		poll(tone_port_pkg::A_STATUS, tone_port_pkg::EV_INIT);
		e = '{6'h10, 6'h30, 6'h30, 6'h38, 6'h30, 6'h10, {3'h7, cfg[2:0]}, {2'h3, cfg[7:4]}};
		for (i = 0; i < 8; i++)
			chk("init access", e[i], ops[i] & (e[i][5] ? 6'h3F : 6'h30));
		chk("modes", {cfg[1], cfg[7:5]}, {cp_sel, column_tone, single_tone, test_mode});
		chk("irq masked", 1'b0, irq);
		apb(1'b1, tone_port_pkg::A_TX, 32'h7, q);
		wait_op(6'h30, 6'h20, 8, k);
		chk("tx digit", 4'h7, ops[k][3:0]);
		chk("tone code", 4'h7, tone_code);
		t = op_t[k];
		apb(1'b1, tone_port_pkg::A_TX, 32'h5, q);
		till(t + m * B / 2);
		chk("burst tone", 1'b1, tone_active);
		till(t + 3 * m * B / 2);
		chk("pause tone", 1'b0, tone_active);
		// The digit lands on the edge that sets the ready flag, so one status read shows both.
		till(t + 2 * m * B - 1);
		rx_code <= 4'h5;
		rx_valid <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		wait_op(6'h32, 6'h12, k + 1, k2);
		dt = op_t[k2] - t;
		chk("ready delay", 1'b1, dt >= 2 * m * B && dt <= 2 * m * B + 16);
		wait_op(6'h3F, 6'h25, k2, i);
		chk("rx then tx", 4'h9, {ops[k2][2], ops[k2 + 1][5:4], i == k2 + 2});
		poll(tone_port_pkg::A_STATUS, tone_port_pkg::EV_RX);
		apb(1'b0, tone_port_pkg::A_RX, 32'h0, q);
		chk("rx digit", 32'h5, q);
		apb(1'b1, tone_port_pkg::A_MASK, 32'h7, q);
		@(posedge pclk);
		chk("irq raised", 1'b1, irq);
		apb(1'b1, tone_port_pkg::A_STATUS, 32'h7, q);
		apb(1'b0, tone_port_pkg::A_STATUS, 32'h0, q);
		chk("events cleared", 3'h0, q[2:0]);
		chk("steer bit", m[1], q[11]);
		chk("irq cleared", 1'b0, irq);
		apb(1'b1, tone_port_pkg::A_MASK, 32'h0, q);
		apb(1'b0, 8'h20, 32'h0, q);
		chk("unmapped err", 1'b1, slverr_q);
		chk("unmapped data", 32'h0, q);
		$display("phase %0d done", m);
	endtask
	// ==========
	// Main sequence: polled plain burst, then interrupt-driven extended burst with steering raised
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_valid = 1'b0;
		rx_code = 4'h0;
		steer_absent = 1'b0;
		cur_v = 1'b0;
		@(posedge pclk);
		phase(9'h105, 1);
		phase(9'h007, 2);
		summarize();
	end
endmodule
